/* File: msa_adapter.sv */
// Manchester serial adapter: transmit clock and encoder, receive carrier,
// collision qualifier, decoder and receive clock selection.
// Assumes all pins are asynchronous to ref_clk_i and the oscillator pin is slow.
//
// Contract
// - Transmit clock toggles on each oscillator rise.
// - Encode data on oscillator fall after clock rise.
// - Each half bit cell lasts about 50 ns.
// - Receive data undefined until decoded bit five.
// - Test select low gives recovered receive clock.
// - Clock switch may glitch after bit two.
// - Carrier drops 1.55 bits after last rise; here the hold restarts on either edge, so it runs from the last transition.
// - Reject 20 ns receive pulses, accept 45 ns.
// - Reject 10 ns collision pulses, accept 26 ns.
// - Collision bridges 80 ns gaps, off at 160.
// - Tolerate 16 ns jitter during acquisition.
// - Tolerate 19 ns jitter after fifty bits.
module msa_adapter
    import msa_pkg::*;
#(
    parameter int FIRST_BIT = FIRST_DATA_BIT
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic oscillator_input_i,
    input wire logic transmit_enable_in_i,
    input wire logic tx_data_i,
    input wire logic test_select_i,
    input wire logic rx_line_i,
    input wire logic collision_line_i,
    output logic transmit_clock_out_o,
    output logic tx_line_o,
    output logic receive_clock_o,
    output logic rx_data_o,
    output logic receive_enable_out_o,
    output logic collision_indicate_o
);

    // Data must start after the clock switch and within the bit counter
    if (FIRST_BIT <= CLK_SWITCH_BIT || FIRST_BIT >= (1 << BITCNT_W) - 1) begin : g_chk
        $error("msa_adapter: FIRST_BIT out of range");
    end

    // Pin synchronisers; stage 0 feeds stage 1 only, stage 2 is the edge history
    logic [2:0] osc_s_q, osc_s_d;
    logic [2:0] rxl_s_q, rxl_s_d;
    logic [1:0] transmit_enable_in_s_q, transmit_enable_in_s_d;
    logic [1:0] txd_s_q, txd_s_d;
    logic [1:0] tsel_s_q, tsel_s_d;
    logic [1:0] col_s_q, col_s_d;
    logic osc_rise; // Oscillator rising edge seen
    logic osc_fall; // Oscillator falling edge seen
    logic rx_edge; // Any receive line transition

    // Next values of the synchronisers
    always_comb begin
        osc_s_d = {osc_s_q[1:0], oscillator_input_i};
        rxl_s_d = {rxl_s_q[1:0], rx_line_i};
        transmit_enable_in_s_d = {transmit_enable_in_s_q[0], transmit_enable_in_i};
        txd_s_d = {txd_s_q[0], tx_data_i};
        tsel_s_d = {tsel_s_q[0], test_select_i};
        col_s_d = {col_s_q[0], collision_line_i};
    end

    // Synchroniser registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            osc_s_q <= '0;
            rxl_s_q <= '0;
            transmit_enable_in_s_q <= '0;
            txd_s_q <= '0;
            tsel_s_q <= '0;
            col_s_q <= '0;
        end else begin
            osc_s_q <= osc_s_d;
            rxl_s_q <= rxl_s_d;
            transmit_enable_in_s_q <= transmit_enable_in_s_d;
            txd_s_q <= txd_s_d;
            tsel_s_q <= tsel_s_d;
            col_s_q <= col_s_d;
        end
    end

    assign osc_rise = osc_s_q[1] & ~osc_s_q[2];
    assign osc_fall = ~osc_s_q[1] & osc_s_q[2];
    assign rx_edge = rxl_s_q[1] ^ rxl_s_q[2];

    // Transmit side state
    logic transmit_clock_out_q, transmit_clock_out_d; // Divided transmit clock
    msa_tx_t enc_q, enc_d; // Cell sampled at transmit clock rise
    logic tx_line_q, tx_line_d; // Encoded line, idles high
    logic [PHASE_W-1:0] half_cnt_q, half_cnt_d; // Cycles since line change

    // Transmit clock divider and encoder
    always_comb begin
        transmit_clock_out_d = transmit_clock_out_q;
        enc_d = enc_q;
        tx_line_d = tx_line_q;
        if (osc_rise) begin
            // Reset value is arbitrary; nothing relies on the phase
            transmit_clock_out_d = ~transmit_clock_out_q;
            if (!transmit_clock_out_q) begin
                // Controller data stable around this edge
                enc_d.active = transmit_enable_in_s_q[1];
                enc_d.value = txd_s_q[1];
            end
        end
        if (osc_fall) begin
            // Halves follow oscillator falls, exactly one half cell apart
            if (enc_q.active) begin
                tx_line_d = transmit_clock_out_q ? ~enc_q.value : enc_q.value;
            end else begin
                tx_line_d = 1'b1;
            end
        end
        if (tx_line_d != tx_line_q) begin
            half_cnt_d = '0;
        end else begin
            half_cnt_d = (half_cnt_q == '1) ? half_cnt_q : half_cnt_q + 1'b1;
        end
    end

    // Transmit registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            transmit_clock_out_q <= 1'b0;
            enc_q <= '0;
            tx_line_q <= 1'b1;
            half_cnt_q <= '0;
        end else begin
            transmit_clock_out_q <= transmit_clock_out_d;
            enc_q <= enc_d;
            tx_line_q <= tx_line_d;
            half_cnt_q <= half_cnt_d;
        end
    end

    // Carrier and collision qualifiers
    logic carrier; // Internal carrier sense
    logic collision; // Qualified collision

    msa_pulse_qual #(
        .ON_CYC(RX_ON_CYC),
        .HOLD_CYC(CARR_HOLD_CYC),
        .EDGE_RESTART(1'b1)
    ) u_carrier (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .line_i(rxl_s_q[1]),
        .active_o(carrier)
    );

    msa_pulse_qual #(
        .ON_CYC(COLLISION_INDICATE_ON_CYC),
        .HOLD_CYC(COLLISION_INDICATE_OFF_CYC),
        .EDGE_RESTART(1'b0)
    ) u_collision (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .line_i(col_s_q[1]),
        .active_o(collision)
    );

    // Decoder state
    logic [PHASE_W-1:0] phase_q, phase_d; // Position inside the bit cell
    logic [BITCNT_W-1:0] bit_cnt_q, bit_cnt_d; // Decoded bits, saturating
    logic [1:0] sw_cnt_q, sw_cnt_d; // Recovered clock rises after bit two
    logic rec_clk_q, rec_clk_d; // Internal recovered clock
    logic use_rec_q, use_rec_d; // Receive clock taken from recovery
    msa_rx_t rx_q, rx_d; // Registered receive outputs
    logic in_window; // Edge far enough from the last centre
    logic accept; // Edge taken as a cell centre

    // Acceptance window, open for the first centre, then equally wide before and after the decoder has settled
    always_comb begin
        if (bit_cnt_q == '0) begin
            in_window = 1'b1;
        end else if (bit_cnt_q < BITCNT_W'(JIT_RUN_BITS)) begin
            // Phase lags the edge by one cycle, so the late bound is exclusive
            in_window = phase_q >= PHASE_W'(ACQ_BLANK_CYC)
                || phase_q < PHASE_W'(ACQ_LATE_CYC);
        end else begin
            in_window = phase_q >= PHASE_W'(RUN_BLANK_CYC)
                || phase_q < PHASE_W'(RUN_LATE_CYC);
        end
        accept = carrier && rx_edge && in_window;
    end

    // Decoder, recovered clock and receive clock selection
    always_comb begin
        phase_d = phase_q;
        bit_cnt_d = bit_cnt_q;
        sw_cnt_d = sw_cnt_q;
        use_rec_d = use_rec_q;
        rx_d.data = rx_q.data;
        if (!carrier) begin
            // End of frame returns to the local clock
            phase_d = '0;
            bit_cnt_d = '0;
            sw_cnt_d = '0;
            use_rec_d = 1'b0;
            rx_d.data = 1'b0;
        end else if (accept) begin
            // Centre transition: rising edge decodes as one
            phase_d = '0;
            bit_cnt_d = (bit_cnt_q == '1) ? bit_cnt_q : bit_cnt_q + 1'b1;
            if (bit_cnt_q >= BITCNT_W'(FIRST_BIT - 1)) begin
                rx_d.data = rxl_s_q[1]; // Preamble bits before this are swallowed
            end
        end else begin
            phase_d = (phase_q == PHASE_W'(BIT_CYC - 1)) ? '0 : phase_q + 1'b1;
        end
        // Rises mid cell, where data is stable for the controller
        rec_clk_d = carrier && (phase_d >= PHASE_W'(HALF_CELL_CYC));
        if (carrier && !use_rec_q && bit_cnt_q >= BITCNT_W'(CLK_SWITCH_BIT)
            && rec_clk_d && !rec_clk_q) begin
            // Switch at the second recovered rise; a short clock may result
            if (sw_cnt_q == 2'(CLK_SWITCH_EDGES - 1)) begin
                use_rec_d = 1'b1;
            end else begin
                sw_cnt_d = sw_cnt_q + 1'b1;
            end
        end
        if (!tsel_s_q[1] || use_rec_d) begin
            rx_d.clock = rec_clk_d; // Test select low forces recovery
        end else begin
            rx_d.clock = transmit_clock_out_d;
        end
        rx_d.enable = carrier;
    end

    // Decoder registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phase_q <= '0;
            bit_cnt_q <= '0;
            sw_cnt_q <= '0;
            rec_clk_q <= 1'b0;
            use_rec_q <= 1'b0;
            rx_q <= '0;
        end else begin
            phase_q <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            sw_cnt_q <= sw_cnt_d;
            rec_clk_q <= rec_clk_d;
            use_rec_q <= use_rec_d;
            rx_q <= rx_d;
        end
    end

    // Outputs, all from registers
    assign transmit_clock_out_o = transmit_clock_out_q;
    assign tx_line_o = tx_line_q;
    assign receive_clock_o = rx_q.clock;
    assign rx_data_o = rx_q.data;
    assign receive_enable_out_o = rx_q.enable;
    assign collision_indicate_o = collision;

    default clocking cb_a @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Transmit clock changes exactly after oscillator rises
    property p_transmit_clock_out_toggle;
        $past(rst_n_i) |-> ((transmit_clock_out_q != $past(transmit_clock_out_q)) == $past(osc_rise));
    endproperty
    a_transmit_clock_out_toggle: assert property (p_transmit_clock_out_toggle)
        else $error("transmit clock toggle not tied to oscillator rise");

    // First half carries the inverted bit, second half the bit
    property p_encode;
        (osc_fall && transmit_clock_out_q && enc_q.active)
            |=> (tx_line_q == ~$past(enc_q.value)) ##5 (tx_line_q == $past(enc_q.value, 6));
    endproperty
    a_encode: assert property (p_encode)
        else $error("Manchester halves encoded wrongly");

    // No line change before a full half cell while encoding
    property p_half_cell;
        ($changed(tx_line_q) && $past(enc_q.active, 2))
            |-> $past(half_cnt_q) >= PHASE_W'(HALF_CELL_CYC - 1);
    endproperty
    a_half_cell: assert property (p_half_cell)
        else $error("transmit half cell too short");

    // Data held low before the first data bit, taken at it
    property p_first_bit;
        (accept && bit_cnt_q == BITCNT_W'(FIRST_BIT - 1)) |=> rx_q.data == $past(rxl_s_q[1]);
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first data bit not presented");

    property p_no_early_data;
        (bit_cnt_q < BITCNT_W'(FIRST_BIT)) |-> !rx_q.data;
    endproperty
    a_no_early_data: assert property (p_no_early_data)
        else $error("receive data shown before first data bit");

    // Test select low: receive clock follows the recovered clock
    property p_test_clock;
        !tsel_s_q[1] |=> rx_q.clock == rec_clk_q;
    endproperty
    a_test_clock: assert property (p_test_clock)
        else $error("receive clock not recovered clock under test select");

    // Switch only after bit two, on a recovered rise
    property p_switch;
        $rose(use_rec_q) |-> $past(bit_cnt_q) >= BITCNT_W'(CLK_SWITCH_BIT)
            && rec_clk_q && !$past(rec_clk_q);
    endproperty
    a_switch: assert property (p_switch)
        else $error("receive clock switched at wrong point");

    // Accepted centres respect the acquisition window
    property p_acq_window;
        (accept && bit_cnt_q != '0 && bit_cnt_q < BITCNT_W'(JIT_RUN_BITS))
            |-> phase_q >= PHASE_W'(ACQ_BLANK_CYC) || phase_q < PHASE_W'(ACQ_LATE_CYC);
    endproperty
    a_acq_window: assert property (p_acq_window)
        else $error("edge accepted outside acquisition window");

    // Settled decoder window, then phase restarts
    property p_run_window;
        (accept && bit_cnt_q >= BITCNT_W'(JIT_RUN_BITS))
            |-> (phase_q >= PHASE_W'(RUN_BLANK_CYC) || phase_q < PHASE_W'(RUN_LATE_CYC))
            ##1 phase_q == '0;
    endproperty
    a_run_window: assert property (p_run_window)
        else $error("edge accepted outside settled window");

    c_frame_data: cover property (rx_q.enable && bit_cnt_q == BITCNT_W'(FIRST_BIT));
    c_switch: cover property ($rose(use_rec_q));
    c_collision: cover property ($rose(collision_indicate_o));
    c_long_frame: cover property (accept && bit_cnt_q == BITCNT_W'(JIT_RUN_BITS));

endmodule

/* File: msa_adapter_tb_top.sv */
// Self-checking bench for the Manchester serial adapter.
// Assumes the adapter guards its own timing with assertions in its files.
module msa_adapter_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk_i = 1'b0; // 100 MHz reference
    logic rst_n_i = 1'b0;
    logic osc = 1'b0; // 20 MHz oscillator pin
    logic tsel = 1'b0; // Receive clock select
    logic rx_line = 1'b0; // Receive line, idles low
    logic collision_indicate_line = 1'b0; // Collision line, idles low
    logic tx_en, tx_data, transmit_clock_out, tx_line, rclk, rx_data, receive_enable_out, collision_indicate;
    int failures = 0;
    int total_checks = 0;
    int t_rise = 0; // Time of the last receive line transition
    localparam logic [7:0] frame_byte = 8'ha5; // Ends in a one

    always #5 ref_clk_i = ~ref_clk_i;

    // Offset keeps the oscillator edges off the reference edges
    initial begin
        #3;
        forever #25 osc = ~osc;
    end

    msa_adapter dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .oscillator_input_i(osc),
        .transmit_enable_in_i(tx_en), .tx_data_i(tx_data), .test_select_i(tsel),
        .rx_line_i(rx_line), .collision_line_i(collision_indicate_line),
        .transmit_clock_out_o(transmit_clock_out), .tx_line_o(tx_line), .receive_clock_o(rclk),
        .rx_data_o(rx_data), .receive_enable_out_o(receive_enable_out), .collision_indicate_o(collision_indicate)
    );

    msa_mac_model mac (
        .transmit_clock_out_i(transmit_clock_out), .receive_clock_i(rclk),
        .receive_enable_out_i(receive_enable_out), .rx_data_i(rx_data),
        .transmit_enable_in_o(tx_en), .tx_data_o(tx_data)
    );

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
        end
    endtask

    // Wait n reference edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic test_tx_clock();
        int t0;
        @(posedge transmit_clock_out);
        t0 = int'($time);
        @(negedge transmit_clock_out);
        chk_rng("tx clock high ns", 50, 50, int'($time) - t0);
        @(posedge transmit_clock_out);
        chk_rng("tx clock period ns", 100, 100, int'($time) - t0);
    endtask

    // Bits 0,0,1,0,1,1,0,1: each cell is inverse half, then true half
    task automatic test_tx_encode();
        logic [7:0] pat;
        pat = 8'hb4;
        fork
            mac.send({8'h00, pat}, 8);
            begin
                @(posedge transmit_clock_out);
                @(posedge transmit_clock_out);
                for (int i = 0; i < 8; i++) begin
                    repeat (5) @(posedge ref_clk_i);
                    #2;
                    chk_vec("tx first half", {7'h0, ~pat[i]}, {7'h0, tx_line});
                    repeat (5) @(posedge ref_clk_i);
                    #2;
                    chk_vec("tx second half", {7'h0, pat[i]}, {7'h0, tx_line});
                end
            end
        join
        cyc(10);
        repeat (20) begin
            cyc(1);
            chk_vec("tx idle line", 8'h01, {7'h0, tx_line});
        end
    endtask

    // All ones toggle the line every half cell
    task automatic test_tx_half_cell();
        int t0;
        fork
            mac.send(16'hffff, 8);
            begin
                @(negedge tx_line);
                t0 = int'($time);
                repeat (12) begin
                    @(tx_line);
                    chk_rng("half cell ns", 50, 50, int'($time) - t0);
                    t0 = int'($time);
                end
            end
        join
    endtask

    task automatic test_rx_noise();
        cyc(20);
        rx_line = 1'b1;
        #20;
        rx_line = 1'b0;
        repeat (20) begin
            cyc(1);
            chk_vec("noise carrier", 8'h00, {7'h0, receive_enable_out});
        end
    endtask

    // Preamble 1010.., marker 11, then the byte LSB first; odd centres jittered
    task automatic rx_frame(input int npre, input int ja, input int jr);
        logic b;
        int off;
        for (int i = 0; i < npre + 10; i++) begin
            b = (i < npre) ? ~i[0] : (i < npre + 2) ? 1'b1 : frame_byte[i - npre - 2];
            off = i[0] ? ((i < 50) ? ja : jr) : 0;
            rx_line = ~b;
            #(50 + off);
            rx_line = b;
            #(50 - off);
        end
        // Return to idle is the last activity the carrier can see
        rx_line = 1'b0;
        t_rise = int'($time);
    endtask

    task automatic test_rx(input logic sel, input int npre, input int ja, input int jr);
        int k;
        int n;
        logic [7:0] got;
        k = -1;
        n = 0;
        got = 8'hxx;
        tsel = sel;
        mac.rx_bits_q.delete();
        fork
            rx_frame(npre, ja, jr);
            begin
                #131;
                chk_vec("carrier on", 8'h01, {7'h0, receive_enable_out});
            end
        join
        while (receive_enable_out !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk_rng("carrier hold ns", 150, 200, int'($time) - t_rise);
        for (int i = 0; i + 9 < mac.rx_bits_q.size(); i++) begin
            if (k < 0 && mac.rx_bits_q[i] === 1'b1 && mac.rx_bits_q[i + 1] === 1'b1) begin
                k = i + 2;
            end
        end
        if (k >= 0) begin
            for (int j = 0; j < 8; j++) got[j] = mac.rx_bits_q[k + j];
        end
        chk_vec("received byte", frame_byte, got);
    endtask

    task automatic test_collision();
        collision_indicate_line = 1'b1;
        #10;
        collision_indicate_line = 1'b0;
        repeat (20) begin
            cyc(1);
            chk_vec("short collision", 8'h00, {7'h0, collision_indicate});
        end
        collision_indicate_line = 1'b1;
        #30;
        collision_indicate_line = 1'b0;
        #40;
        chk_vec("collision on", 8'h01, {7'h0, collision_indicate});
        #40;
        // Gaps of 80 ns must not drop the indication
        repeat (3) begin
            collision_indicate_line = 1'b1;
            #30;
            collision_indicate_line = 1'b0;
            repeat (8) begin
                #10;
                chk_vec("collision held", 8'h01, {7'h0, collision_indicate});
            end
        end
        #140;
        chk_vec("collision off", 8'h00, {7'h0, collision_indicate});
    endtask

    task automatic test_rclk_sel();
        int n;
        logic prev;
        n = 0;
        prev = rclk;
        tsel = 1'b0;
        repeat (20) begin
            cyc(1);
            chk_vec("idle receive clock", 8'h00, {7'h0, rclk});
        end
        tsel = 1'b1;
        cyc(5);
        repeat (100) begin
            cyc(1);
            if (rclk === 1'b1 && prev === 1'b0) n++;
            prev = rclk;
        end
        chk_rng("local receive clock rises", 9, 11, n);
    endtask

    // Main sequence
    initial begin
        cyc(10);
        rst_n_i = 1'b1;
        cyc(5);
        test_tx_clock();
        test_tx_encode();
        test_tx_half_cell();
        test_rx_noise();
        test_rx(1'b0, 8, 16, 16);
        test_collision();
        test_rclk_sel();
        test_rx(1'b1, 56, 16, 19);
        end_sim();
    end

    // The run needs about 14 us; a hang is cut well after that
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule

/* File: msa_mac_model.sv */
// Controller model on the serial side of the adapter: sends transmit bits and
// collects received bits. Assumes the adapter's clocks come from one 100 MHz domain.
module msa_mac_model (
    input wire logic transmit_clock_out_i,
    input wire logic receive_clock_i,
    input wire logic receive_enable_out_i,
    input wire logic rx_data_i,
    output logic transmit_enable_in_o,
    output logic tx_data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic rx_bits_q[$]; // Bits taken while receive is enabled

    // Idle: not transmitting
    initial begin
        transmit_enable_in_o = 1'b0;
        tx_data_o = 1'b0;
    end

    // Launch each bit just after a transmit clock rise
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge transmit_clock_out_i);
            #1;
            transmit_enable_in_o = 1'b1;
            tx_data_o = bits[i];
        end
        @(posedge transmit_clock_out_i);
        #1;
        transmit_enable_in_o = 1'b0;
        // Released data shows its inverse, so a stale bit cannot pass for good
        tx_data_o = ~tx_data_o;
    endtask

    // Take data on receive clock rises while receive is enabled
    always @(posedge receive_clock_i) begin
        if (receive_enable_out_i === 1'b1) begin
            rx_bits_q.push_back(rx_data_i);
        end
    end
endmodule

/* File: msa_pkg.sv */
// Constants, timing counts and carrier types of the Manchester serial adapter.
// Assumes one 100 MHz reference clock; each time below that sets a count becomes whole cycles of it.
package msa_pkg;

    // Reference clock and line rate
    localparam real CLK_PERIOD_NS = 10.0;
    localparam real BIT_TIME_NS = 100.0;
    localparam int BIT_CYC = int'($floor(BIT_TIME_NS / CLK_PERIOD_NS));

    // Transmit half bit cell limits
    localparam real HALF_CELL_MIN_NS = 49.5;
    localparam real HALF_CELL_MAX_NS = 50.5;
    localparam int HALF_CELL_CYC = int'($floor(HALF_CELL_MAX_NS / CLK_PERIOD_NS));

    // Receive line pulse qualification
    localparam real RX_REJECT_NS = 20.0;
    localparam real RX_TURN_ON_NS = 45.0;
    localparam int RX_ON_CYC = int'($floor(RX_REJECT_NS / CLK_PERIOD_NS)) + 1;

    // Carrier hold after the last receive line transition, in bit times
    localparam real CARR_HOLD_BITS = 1.55;
    localparam int CARR_HOLD_CYC = int'($floor(CARR_HOLD_BITS * BIT_TIME_NS / CLK_PERIOD_NS));

    // Collision pulse qualification and hold
    localparam real COLLISION_INDICATE_REJECT_NS = 10.0;
    localparam real COLLISION_INDICATE_TURN_ON_NS = 26.0;
    localparam real COLLISION_INDICATE_GAP_NS = 80.0;
    localparam real COLLISION_INDICATE_OFF_NS = 160.0;
    localparam int COLLISION_INDICATE_ON_CYC = int'($floor(COLLISION_INDICATE_REJECT_NS / CLK_PERIOD_NS)) + 1;
    localparam int COLLISION_INDICATE_OFF_CYC = int'($floor(COLLISION_INDICATE_OFF_NS / CLK_PERIOD_NS));

    // Decoder edge jitter tolerance, acquisition and steady state
    localparam real JIT_ACQ_MIN_NS = 16.0;
    localparam real JIT_ACQ_MAX_NS = 21.5;
    localparam real JIT_RUN_MIN_NS = 19.0;
    localparam real JIT_RUN_MAX_NS = 24.4;
    localparam int JIT_RUN_BITS = 50;
    localparam int ACQ_BLANK_CYC =
        int'($ceil((BIT_TIME_NS / 2.0 + JIT_ACQ_MIN_NS) / CLK_PERIOD_NS));
    localparam int ACQ_LATE_CYC = int'($floor(JIT_ACQ_MAX_NS / CLK_PERIOD_NS));
    localparam int RUN_BLANK_CYC =
        int'($ceil((BIT_TIME_NS / 2.0 + JIT_RUN_MIN_NS) / CLK_PERIOD_NS));
    localparam int RUN_LATE_CYC = int'($floor(JIT_RUN_MAX_NS / CLK_PERIOD_NS));

    // Receive sequence points, counted in decoded bits and recovered clock rises
    localparam int FIRST_DATA_BIT = 5;
    localparam int CLK_SWITCH_BIT = 2;
    localparam int CLK_SWITCH_EDGES = 2;

    // Counter widths
    localparam int PULSE_CW = 5;
    localparam int PHASE_W = 4;
    localparam int BITCNT_W = 6;

    // Receive side outputs travel together
    typedef struct packed {
        logic clock;
        logic enable;
        logic data;
    } msa_rx_t;

    // Transmit cell being encoded
    typedef struct packed {
        logic active;
        logic value;
    } msa_tx_t;

endpackage

/* File: msa_pulse_qual.sv */
// Pulse width qualifier with hold-off timer, used for carrier and collision.
// Assumes line_i is already synchronised to ref_clk_i.
module msa_pulse_qual
    import msa_pkg::*;
#(
    parameter int ON_CYC = 3,
    parameter int HOLD_CYC = 15,
    parameter bit EDGE_RESTART = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic line_i,
    output logic active_o
);

    // Counters must hold the largest count
    if (ON_CYC < 1 || HOLD_CYC < 2
        || ON_CYC >= (1 << PULSE_CW) || HOLD_CYC >= (1 << PULSE_CW)) begin : g_chk
        $error("msa_pulse_qual: counts do not fit");
    end

    logic prev_q, prev_d; // Line one cycle ago
    logic [PULSE_CW-1:0] run_q, run_d; // Length of current high run
    logic [PULSE_CW-1:0] quiet_q, quiet_d; // Cycles since last activity
    logic act_q, act_d; // Qualified indication
    logic restart; // Activity that keeps the indication alive

    // Next state of run, quiet timer and indication
    always_comb begin
        // Either polarity retriggers: an alternating preamble rises only every
        // second bit time, which would outlast the 1.55 bit hold
        restart = EDGE_RESTART ? (line_i ^ prev_q) : line_i;
        prev_d = line_i;
        run_d = line_i ? ((run_q == '1) ? run_q : run_q + 1'b1) : '0;
        act_d = act_q;
        quiet_d = quiet_q;
        if (!act_q) begin
            // Short pulses never reach the threshold
            quiet_d = '0;
            if (line_i && run_q == PULSE_CW'(ON_CYC - 1)) begin
                act_d = 1'b1;
            end
        end else if (restart) begin
            quiet_d = '0; // Gap bridged
        end else if (quiet_q == PULSE_CW'(HOLD_CYC - 1)) begin
            act_d = 1'b0; // Quiet long enough, end of activity
            quiet_d = '0;
        end else begin
            quiet_d = quiet_q + 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
            run_q <= '0;
            quiet_q <= '0;
            act_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            run_q <= run_d;
            quiet_q <= quiet_d;
            act_q <= act_d;
        end
    end

    assign active_o = act_q;

    default clocking cb_q @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Turn-on only after the full qualifying width
    property p_turn_on;
        $rose(act_q) |-> ($past(run_q) == PULSE_CW'(ON_CYC - 1)) && $past(line_i);
    endproperty
    a_turn_on: assert property (p_turn_on)
        else $error("indication rose without qualifying pulse width");

    // Turn-off only after the whole quiet time
    property p_turn_off;
        $fell(act_q) |-> $past(quiet_q) == PULSE_CW'(HOLD_CYC - 1) && !$past(restart);
    endproperty
    a_turn_off: assert property (p_turn_off)
        else $error("indication fell before quiet time elapsed");

    // Short gaps never drop the indication
    property p_stay_on;
        (act_q && quiet_q < PULSE_CW'(HOLD_CYC - 1)) |=> act_q;
    endproperty
    a_stay_on: assert property (p_stay_on)
        else $error("indication dropped inside a short gap");

endmodule
